// *** verilog/dual_ddr_dac_input_port.sv ***
/*
  receive side of a dual 14-bit converter in dual-bus mode: two ddr lane
  receivers, a sample buffer per channel, the transmit gate and sleep
  handling, the inverted-sense code to the current cells and the serial
  output pin enables.
  assumes the pins arrive asynchronously and the converter pulls samples
  through i_chan_x_sample_ready on i_ref_clk.
*/
`timescale 1ns/1ps
module dual_ddr_dac_input_port
  import ddr_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic                i_chan_a_data_clock,
  input  wire logic [LANE_W-1:0]   i_chan_a_lanes,
  input  wire logic                i_chan_b_data_clock,
  input  wire logic [LANE_W-1:0]   i_chan_b_lanes,
  input  wire logic                i_bus_reverse,
  input  wire logic                i_transmit_gate,
  input  wire logic                i_sleep,
  input  wire logic                i_chan_a_sample_ready,
  input  wire logic                i_chan_b_sample_ready,
  output logic [SAMPLE_W-1:0]      o_chan_a_code,
  output logic [SAMPLE_W-1:0]      o_chan_b_code,
  output logic [SAMPLE_W-1:0]      o_chan_a_positive_current_out,
  output logic [SAMPLE_W-1:0]      o_chan_b_positive_current_out,
  output logic                     o_chan_a_overrun,
  output logic                     o_chan_b_overrun,
  output logic                     o_sleep_state,
  output logic                     o_datapath_active,
  input  wire logic                i_four_wire_serial_select,
  input  wire logic                i_serial_read_active,
  input  wire logic                i_serial_read_bit,
  output logic                     o_serial_out_pin,
  output logic                     o_serial_out_pin_oe,
  input  wire logic                i_sdio_in,
  output logic                     o_sdio_out,
  output logic                     o_sdio_oe,
  output logic                     o_serial_in_bit
);

  logic                 gate_s1_q;
  logic                 gate_s2_q;
  logic                 sleep_s1_q;
  logic                 sleep_s2_q;
  logic                 sdio_s1_q;
  logic                 sdio_s2_q;
  logic                 active_w;

  logic [CHANNELS-1:0]  data_clock_w;
  logic [LANE_W-1:0]    lanes_w     [CHANNELS];
  logic [CHANNELS-1:0]  cap_valid_w;
  logic [SAMPLE_W-1:0]  cap_sample_w [CHANNELS];
  logic [CHANNELS-1:0]  fifo_in_ready_w;
  logic [CHANNELS-1:0]  fifo_out_valid_w;
  logic [SAMPLE_W-1:0]  fifo_out_data_w [CHANNELS];
  logic [CHANNELS-1:0]  sample_ready_w;
  logic [CHANNELS-1:0]  pop_w;
  logic [CHANNELS-1:0]  push_w;
  logic [SAMPLE_W-1:0]  code_q    [CHANNELS];
  logic [SAMPLE_W-1:0]  current_q [CHANNELS];
  logic [CHANNELS-1:0]  overrun_q;

  // pins are asynchronous to the reference clock
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gate_s1_q  <= 1'b0;
      gate_s2_q  <= 1'b0;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      sdio_s1_q  <= 1'b0;
      sdio_s2_q  <= 1'b0;
    end
    else
    begin
      gate_s1_q  <= i_transmit_gate;
      gate_s2_q  <= gate_s1_q;
      sleep_s1_q <= i_sleep;
      sleep_s2_q <= sleep_s1_q;
      sdio_s1_q  <= i_sdio_in;
      sdio_s2_q  <= sdio_s1_q;
    end
  end

  // sleeping also stops the datapath: a sleeping converter takes no samples
  assign active_w = gate_s2_q & ~sleep_s2_q;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sleep_state     <= 1'b0;
      o_datapath_active <= 1'b0;
    end
    else
    begin
      o_sleep_state     <= sleep_s2_q;
      o_datapath_active <= active_w;
    end
  end

  assign data_clock_w   = {i_chan_b_data_clock, i_chan_a_data_clock};
  assign lanes_w[0]     = i_chan_a_lanes;
  assign lanes_w[1]     = i_chan_b_lanes;
  assign sample_ready_w = {i_chan_b_sample_ready, i_chan_a_sample_ready};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      // each channel has its own capture, so the two data clocks never meet
      ddr_lane_capture #(
        .LW (LANE_W)
      ) u_capture (
        .i_ref_clk     (i_ref_clk),
        .i_rst         (i_rst),
        .i_data_clock  (data_clock_w[ch]),
        .i_lanes       (lanes_w[ch]),
        .i_bus_reverse (i_bus_reverse),
        .i_enable      (active_w),
        .o_valid       (cap_valid_w[ch]),
        .o_sample      (cap_sample_w[ch])
      );

      assign push_w[ch] = cap_valid_w[ch] & fifo_in_ready_w[ch] & active_w;
      assign pop_w[ch]  = fifo_out_valid_w[ch] & sample_ready_w[ch] & active_w;

      // the link cannot be stalled, so a full buffer drops the sample and says so
      sample_fifo #(
        .W     (SAMPLE_W),
        .DEPTH (DEPTH)
      ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_flush     (~active_w),
        .i_in_valid  (push_w[ch]),
        .o_in_ready  (fifo_in_ready_w[ch]),
        .i_in_data   (cap_sample_w[ch]),
        .o_out_valid (fifo_out_valid_w[ch]),
        .i_out_ready (sample_ready_w[ch] & active_w),
        .o_out_data  (fifo_out_data_w[ch])
      );

      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          code_q[ch]    <= ZERO_CODE;
          current_q[ch] <= ~ZERO_CODE;
          overrun_q[ch] <= 1'b0;
        end
        else
        begin
          overrun_q[ch] <= cap_valid_w[ch] & active_w & ~fifo_in_ready_w[ch];
          if (!active_w)
          begin
            code_q[ch]    <= ZERO_CODE;
            current_q[ch] <= ~ZERO_CODE;
          end
          else if (pop_w[ch])
          begin
            code_q[ch]    <= fifo_out_data_w[ch];
            current_q[ch] <= ~fifo_out_data_w[ch];
          end
        end
      end
    end
  endgenerate

  assign o_chan_a_code                 = code_q[0];
  assign o_chan_b_code                 = code_q[1];
  assign o_chan_a_positive_current_out = current_q[0];
  assign o_chan_b_positive_current_out = current_q[1];
  assign o_chan_a_overrun              = overrun_q[0];
  assign o_chan_b_overrun              = overrun_q[1];

  // serial pins: the enables are combinational so the pin turns with the mode bit
  assign o_serial_out_pin    = i_serial_read_bit;
  assign o_serial_out_pin_oe = i_four_wire_serial_select & i_serial_read_active;
  assign o_sdio_out          = i_serial_read_bit;
  assign o_sdio_oe           = ~i_four_wire_serial_select & i_serial_read_active;
  assign o_serial_in_bit     = sdio_s2_q;

  sequence s_gate_drop;
    gate_s2_q ##1 !gate_s2_q;
  endsequence

  a_gate_zeroes_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_gate_drop |=> (o_chan_a_code == ZERO_CODE && o_chan_b_code == ZERO_CODE))
    else $error("gate low did not zero the datapath");

  a_gate_blocks_push: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !active_w |-> (push_w == '0 && pop_w == '0))
    else $error("sample accepted while gate low");

  a_gate_holds_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!active_w)[*2] |-> (o_chan_a_code == ZERO_CODE && o_chan_b_code == ZERO_CODE))
    else $error("code not zero while gated");

  a_sleep_follows_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(sleep_s2_q) |=> (o_sleep_state && !o_datapath_active))
    else $error("sleep pin high without sleep state");

  a_wake_on_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!sleep_s2_q && gate_s2_q) |=> (!o_sleep_state && o_datapath_active))
    else $error("sleep pin low but device not running");

  a_inverted_sense_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_chan_a_positive_current_out == ~o_chan_a_code)
    else $error("channel a current sense not inverted");

  a_inverted_sense_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_chan_b_positive_current_out == ~o_chan_b_code)
    else $error("channel b current sense not inverted");

  a_sdo_three_wire: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_four_wire_serial_select |-> !o_serial_out_pin_oe)
    else $error("serial out driven in three-wire mode");

  a_sdo_four_wire: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_four_wire_serial_select && i_serial_read_active) |-> o_serial_out_pin_oe)
    else $error("serial out not driven in four-wire read");

  a_sdio_input_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_four_wire_serial_select |-> !o_sdio_oe)
    else $error("data pin driven in four-wire mode");

  a_sdio_bidir: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!i_four_wire_serial_select && i_serial_read_active) |-> o_sdio_oe)
    else $error("data pin not driven in three-wire read");

  a_pop_loads_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pop_w[0] |=> (o_chan_a_code == $past(fifo_out_data_w[0])))
    else $error("channel a code not loaded on pop");

  a_channels_independent: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (active_w && !pop_w[1]) |=> $stable(o_chan_b_code))
    else $error("channel b changed without its own sample");

  a_channel_a_independent: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (active_w && !pop_w[0]) |=> $stable(o_chan_a_code))
    else $error("channel a changed without its own sample");

  a_pop_loads_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pop_w[1] |=> (o_chan_b_code == $past(fifo_out_data_w[1])))
    else $error("channel b code not loaded on pop");

  a_pop_current_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pop_w[0] |=> (o_chan_a_positive_current_out == ~$past(fifo_out_data_w[0])))
    else $error("channel a current not inverse of popped code");

  a_pop_current_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pop_w[1] |=> (o_chan_b_positive_current_out == ~$past(fifo_out_data_w[1])))
    else $error("channel b current not inverse of popped code");

  // a gated converter must source full scale, the current of code zero
  a_gate_full_scale: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_gate_drop |=> (o_chan_a_positive_current_out == ~ZERO_CODE &&
                     o_chan_b_positive_current_out == ~ZERO_CODE))
    else $error("gate low did not give full-scale current");

  a_gate_low_inactive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !gate_s2_q |=> !o_datapath_active)
    else $error("datapath active while gate low");

  sequence s_sleep_rise;
    !sleep_s2_q ##1 sleep_s2_q;
  endsequence

  a_sleep_clears_codes: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_sleep_rise |=> (o_chan_a_code == ZERO_CODE && o_chan_b_code == ZERO_CODE))
    else $error("sleep did not zero the datapath");

  a_sleep_blocks_push: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sleep_s2_q |-> (push_w == '0 && pop_w == '0))
    else $error("sample accepted while asleep");

  a_sdo_carries_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_serial_out_pin_oe |-> (o_serial_out_pin == i_serial_read_bit))
    else $error("serial out pin not showing read data");

  a_sdio_carries_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_sdio_oe |-> (o_sdio_out == i_serial_read_bit))
    else $error("data pin not showing read data");

  a_sdo_idle_released: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_serial_read_active |-> !o_serial_out_pin_oe)
    else $error("serial out driven with no read");

  a_sdio_idle_released: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_serial_read_active |-> !o_sdio_oe)
    else $error("data pin driven with no read");

endmodule : dual_ddr_dac_input_port

// *** verilog/ddr_port_pkg.sv ***
/*
  shared constants of the dual ddr converter input port: lane and sample
  widths, half-word positions, buffer depth and reset codes.
  assumes the port and the lane capture import the whole package; sample_fifo takes its widths as parameters.
*/
package ddr_port_pkg;

  localparam int          LANE_W       = 7;
  localparam int          SAMPLE_W     = 14;
  localparam int          HI_LSB       = 7;
  localparam int          HI_MSB       = 13;
  localparam int          LO_MSB       = 6;
  localparam int          CHANNELS     = 2;
  localparam int          FIFO_DEPTH   = 16;
  localparam logic [13:0] ZERO_CODE    = 14'h0000;
  localparam logic [6:0]  ZERO_HALF    = 7'h00;
  // link clock is 320 ns, ref clock 40 ns: a half period is this many ref cycles
  localparam int          LINK_HALF_NS = 160;
  localparam int          REF_NS       = 40;
  localparam int          HALF_CYCLES  = LINK_HALF_NS / REF_NS;

endpackage : ddr_port_pkg

// *** verilog/ddr_lane_capture.sv ***
/*
  one channel of the ddr receiver: synchronises the data clock and the
  seven lanes into the reference domain, finds both clock edges and pairs
  the rising-edge half-word with the next falling-edge one.
  assumes the data clock is much slower than i_ref_clk and data is
  centred between its edges.
*/
`timescale 1ns/1ps
module ddr_lane_capture
  import ddr_port_pkg::*;
#(
  parameter int LW = LANE_W
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_data_clock,
  input  wire logic [LW-1:0]     i_lanes,
  input  wire logic              i_bus_reverse,
  input  wire logic              i_enable,
  output logic                   o_valid,
  output logic [2*LW-1:0]        o_sample
);

  logic [2:0]    clk_sync_q;
  logic [LW-1:0] lanes_s1_q;
  logic [LW-1:0] lanes_s2_q;
  logic [LW-1:0] hi_q;
  logic          have_hi_q;
  logic          rise_w;
  logic          fall_w;
  logic [LW-1:0] half_w;

  function automatic logic [LW-1:0] lane_order(input logic [LW-1:0] v, input logic rev);
    logic [LW-1:0] r;
    r = v;
    if (rev)
    begin
      for (int i = 0; i < LW; i++)
        r[i] = v[LW-1-i];
    end
    return r;
  endfunction : lane_order

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      clk_sync_q <= 3'h0;
      lanes_s1_q <= '0;
      lanes_s2_q <= '0;
    end
    else
    begin
      clk_sync_q <= {clk_sync_q[1:0], i_data_clock};
      lanes_s1_q <= i_lanes;
      lanes_s2_q <= lanes_s1_q;
    end
  end

  assign rise_w = clk_sync_q[1] & ~clk_sync_q[2];
  assign fall_w = ~clk_sync_q[1] & clk_sync_q[2];
  assign half_w = lane_order(lanes_s2_q, i_bus_reverse);

  // a falling edge with no rising edge before it is dropped, never paired
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hi_q      <= '0;
      have_hi_q <= 1'b0;
      o_valid   <= 1'b0;
      o_sample  <= '0;
    end
    else
    begin
      o_valid <= 1'b0;
      if (!i_enable)
        have_hi_q <= 1'b0;
      else if (rise_w)
      begin
        hi_q      <= half_w;
        have_hi_q <= 1'b1;
      end
      else if (fall_w && have_hi_q)
      begin
        o_sample  <= {hi_q, half_w};
        o_valid   <= 1'b1;
        have_hi_q <= 1'b0;
      end
    end
  end

  sequence s_rise_then_fall;
    (rise_w && i_enable) ##1 (!rise_w && i_enable && !fall_w)[*1] ##[0:8] (fall_w && i_enable);
  endsequence

  a_pair_complete: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_rise_then_fall |=> o_valid)
    else $error("rise then fall gave no sample");

  a_high_half_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rise_w && i_enable) |=> (hi_q == $past(half_w)))
    else $error("rising half-word not held as upper half");

  a_lane_reversal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_bus_reverse |-> (half_w[0] == lanes_s2_q[LW-1] && half_w[LW-1] == lanes_s2_q[0]))
    else $error("lane order not reversed");

  a_sample_layout: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_valid |-> (o_sample[2*LW-1:LW] == $past(hi_q) && o_sample[LW-1:0] == $past(half_w)))
    else $error("sample halves misplaced");

endmodule : ddr_lane_capture

// *** verilog/sample_fifo.sv ***
/*
  synchronous fifo with valid/ready on both sides and a flush input.
  assumes writer and reader share i_ref_clk.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 16
)(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire logic          i_flush,
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [W-1:0]  i_in_data,
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic [W-1:0]       o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_q;
  logic [AW:0]  rd_ptr_q;
  logic         push_w;
  logic         pop_w;

  assign o_in_ready  = (wr_ptr_q - rd_ptr_q) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ptr_q != rd_ptr_q;
  assign o_out_data  = mem[rd_ptr_q[AW-1:0]];
  assign push_w      = i_in_valid & o_in_ready;
  assign pop_w       = o_out_valid & i_out_ready;

  always_ff @(posedge i_ref_clk)
  begin
    if (push_w)
      mem[wr_ptr_q[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else if (i_flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push_w)
        wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      if (pop_w)
        rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
    end
  end

endmodule : sample_fifo

// *** dv/ddr_source_model.sv ***
/*
  upstream source of one ddr channel: sends one 14-bit sample per rising
  edge of i_go as a rising-edge and a falling-edge half-word.
  assumes i_word and i_reverse are settled when i_go rises and that the
  bench waits for o_busy to fall before the next request.
*/
`timescale 1ns/1ps
module ddr_source_model #(
  parameter int LEAD_NS = 13
)(
  input  wire logic        i_go,
  input  wire logic [13:0] i_word,
  input  wire logic        i_reverse,
  output logic             o_data_clock,
  output logic [6:0]       o_lanes,
  output logic             o_busy
);
  function automatic logic [6:0] order(input logic [6:0] h, input logic rev);
    logic [6:0] r;
    for (int i = 0; i < 7; i++)
      r[i] = h[6-i];
    return rev ? r : h;
  endfunction : order

  initial
  begin
    o_data_clock = 1'b0;
    o_lanes      = 7'h55;
    o_busy       = 1'b0;
  end

  // the clock stands still between frames; the lead offset keeps its edges
  // away from the reference clock edges
  always @(posedge i_go)
  begin
    o_busy = 1'b1;
    #(LEAD_NS);
    o_lanes = order(i_word[13:7], i_reverse);
    #80 o_data_clock = 1'b1;
    #80 o_lanes = order(i_word[6:0], i_reverse);
    #80 o_data_clock = 1'b0;
    // hold time over: show the inverse so a stale value cannot pass
    #80 o_lanes = ~o_lanes;
    o_busy = 1'b0;
  end
endmodule : ddr_source_model

// *** dv/dual_ddr_dac_input_port_tb.sv ***
/*
  self-checking bench of the dual ddr input port: two source models feed
  the lanes, the bench pulls samples and drives gate, sleep and serial pins.
  assumes the design package and the source model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(w, e, g) check(w, e, g)
module dual_ddr_dac_input_port_tb
  import ddr_port_pkg::*;
;
  localparam int          LIMIT = 3000;
  localparam logic [13:0] TBL [6] = '{14'h0000, 14'h3FFF, 14'h2A55,
                                      14'h1555, 14'h2001, 14'h0040};
  logic              clk, rst, gate, sleep, rev, rdy_a, rdy_b;
  logic              four, rd_act, rd_bit, sdio_in, go_a, go_b;
  logic [13:0]       word_a, word_b;
  logic              clk_a, clk_b, busy_a, busy_b;
  logic [6:0]        lanes_a, lanes_b;
  logic [13:0]       code_a, code_b, cur_a, cur_b;
  logic              ovr_a, ovr_b, sleep_st, active;
  logic              so_pin, so_oe, sdio_out, sdio_oe, sin_bit;
  int                miscompares = 0;
  int                n_compared  = 0;
  int                cycles      = 0;
  int                ovr_cnt_a   = 0;
  int                ovr_cnt_b   = 0;

  ddr_source_model #(.LEAD_NS(13)) src_a (.i_go(go_a), .i_word(word_a), .i_reverse(rev),
    .o_data_clock(clk_a), .o_lanes(lanes_a), .o_busy(busy_a));
  ddr_source_model #(.LEAD_NS(57)) src_b (.i_go(go_b), .i_word(word_b), .i_reverse(rev),
    .o_data_clock(clk_b), .o_lanes(lanes_b), .o_busy(busy_b));

  dual_ddr_dac_input_port uut (
    .i_ref_clk(clk), .i_rst(rst),
    .i_chan_a_data_clock(clk_a), .i_chan_a_lanes(lanes_a),
    .i_chan_b_data_clock(clk_b), .i_chan_b_lanes(lanes_b),
    .i_bus_reverse(rev), .i_transmit_gate(gate), .i_sleep(sleep),
    .i_chan_a_sample_ready(rdy_a), .i_chan_b_sample_ready(rdy_b),
    .o_chan_a_code(code_a), .o_chan_b_code(code_b),
    .o_chan_a_positive_current_out(cur_a), .o_chan_b_positive_current_out(cur_b),
    .o_chan_a_overrun(ovr_a), .o_chan_b_overrun(ovr_b),
    .o_sleep_state(sleep_st), .o_datapath_active(active),
    .i_four_wire_serial_select(four), .i_serial_read_active(rd_act),
    .i_serial_read_bit(rd_bit), .o_serial_out_pin(so_pin), .o_serial_out_pin_oe(so_oe),
    .i_sdio_in(sdio_in), .o_sdio_out(sdio_out), .o_sdio_oe(sdio_oe),
    .o_serial_in_bit(sin_bit));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [13:0] word_of(input int k);
    return 14'h0011 + 14'(k) * 14'h0123;
  endfunction : word_of

  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one frame per selected channel; waits for both sources, then lets the
  // sample reach the code outputs
  task automatic send(input logic [1:0] sel, input logic [13:0] wa, input logic [13:0] wb);
    int n;
    n = 0;
    word_a <= wa;
    word_b <= wb;
    go_a   <= sel[0];
    go_b   <= sel[1];
    @(posedge clk);
    go_a <= 1'b0;
    go_b <= 1'b0;
    while ((busy_a || busy_b) && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask : send

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    if (ovr_a === 1'b1)
      ovr_cnt_a <= ovr_cnt_a + 1;
    if (ovr_b === 1'b1)
      ovr_cnt_b <= ovr_cnt_b + 1;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("mismatch timeout expected %0d seen %0d", LIMIT, cycles);
      conclude();
    end
  end

  initial
  begin
    {rst, gate, sleep, rev, rdy_a, rdy_b} = 6'h20;
    {four, rd_act, rd_bit, sdio_in, go_a, go_b} = 6'h00;
    word_a = 14'h0000;
    word_b = 14'h0000;
    repeat (15) @(posedge clk);
    `CHK("code_a rst", ZERO_CODE, code_a);
    `CHK("cur_a rst", 14'h3FFF, cur_a);
    @(posedge clk);
    rst   <= 1'b0;
    gate  <= 1'b1;
    rdy_a <= 1'b1;
    rdy_b <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("active", 14'h0001, {13'h0, active});
    $display("test reset done");
    // both channels at once, lane order reversed for the second half
    for (int k = 0; k < 6; k++)
    begin
      rev <= (k >= 3);
      send(2'b11, TBL[k], ~TBL[k]);
      `CHK("code_a", TBL[k], code_a);
      `CHK("code_b", ~TBL[k], code_b);
      `CHK("cur_a", ~TBL[k], cur_a);
      `CHK("cur_b", TBL[k], cur_b);
    end
    send(2'b01, 14'h1234, 14'h0000);
    `CHK("lone a", 14'h1234, code_a);
    `CHK("held b", ~TBL[5], code_b);
    $display("test stream done");
    rdy_a <= 1'b0;
    rdy_b <= 1'b0;
    rev   <= 1'b0;
    for (int k = 0; k <= FIFO_DEPTH; k++)
      send(2'b11, word_of(k), ~word_of(k));
    `CHK("overrun", 14'h0001, 14'(ovr_cnt_a));
    `CHK("overrun b", 14'h0001, 14'(ovr_cnt_b));
    for (int k = 0; k <= FIFO_DEPTH; k++)
    begin
      rdy_a <= 1'b1;
      rdy_b <= 1'b1;
      @(posedge clk);
      rdy_a <= 1'b0;
      rdy_b <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("drain", word_of(k < FIFO_DEPTH ? k : FIFO_DEPTH - 1), code_a);
      `CHK("drain b", ~word_of(k < FIFO_DEPTH ? k : FIFO_DEPTH - 1), code_b);
    end
    $display("test buffer done");
    rdy_a <= 1'b1;
    rdy_b <= 1'b1;
    gate  <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("gate code", ZERO_CODE, code_a);
    `CHK("gate cur", 14'h3FFF, cur_a);
    send(2'b11, 14'h1111, 14'h2222);
    `CHK("gated a", ZERO_CODE, code_a);
    `CHK("gated b", ZERO_CODE, code_b);
    gate <= 1'b1;
    repeat (5) @(posedge clk);
    send(2'b01, 14'h0ACE, 14'h0000);
    `CHK("regate", 14'h0ACE, code_a);
    $display("test gate done");
    sleep <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("sleep", 14'h0001, {13'h0, sleep_st});
    `CHK("slept code", ZERO_CODE, code_a);
    sleep <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("awake", 14'h0000, {13'h0, sleep_st});
    `CHK("awake active", 14'h0001, {13'h0, active});
    $display("test sleep done");
    rd_bit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      four   <= i[1];
      rd_act <= i[0];
      @(negedge clk);
      `CHK("sdo oe", {13'h0, i[1] & i[0]}, {13'h0, so_oe});
      `CHK("sdio oe", {13'h0, ~i[1] & i[0]}, {13'h0, sdio_oe});
      @(posedge clk);
    end
    `CHK("sdo high", 14'h0001, {13'h0, so_pin});
    `CHK("sdio out high", 14'h0001, {13'h0, sdio_out});
    rd_bit  <= 1'b0;
    sdio_in <= 1'b1;
    @(negedge clk);
    `CHK("sdo low", 14'h0000, {13'h0, so_pin});
    `CHK("sdio out low", 14'h0000, {13'h0, sdio_out});
    repeat (4) @(posedge clk);
    `CHK("sdio in", 14'h0001, {13'h0, sin_bit});
    $display("test serial done");
    conclude();
  end
endmodule : dual_ddr_dac_input_port_tb
